//--- rtl/dummy_removed.sv
`timescale 1ns/1ns

//--- rtl/slc_pkg.sv
package slc_pkg;

  // Channel and quad counts
  localparam int NUM_QUADS = 2;
  localparam int CH_PER_QUAD = 4;
  localparam int NUM_CH = NUM_QUADS * CH_PER_QUAD;
  localparam int NUM_CFG_CH = 4;
  localparam int PAR_W = 10;

  // Register byte addresses
  localparam logic [17:0] ADDR_TX_CFG_AC = 18'h30022;
  localparam logic [17:0] ADDR_RX_CFG_AC = 18'h30023;
  localparam logic [17:0] ADDR_TX_CFG_AD = 18'h30032;
  localparam logic [17:0] ADDR_RX_CFG_AD = 18'h30033;
  localparam logic [17:0] ADDR_TX_CFG_BC = 18'h30122;
  localparam logic [17:0] ADDR_RX_CFG_BC = 18'h30123;
  localparam logic [17:0] ADDR_TX_CFG_BD = 18'h30132;
  localparam logic [17:0] ADDR_RX_CFG_BD = 18'h30133;
  localparam logic [17:0] ADDR_ALIGN_A = 18'h30805;
  localparam logic [17:0] ADDR_SFIFO_A = 18'h30814;
  localparam logic [17:0] ADDR_ALIGN_B = 18'h30905;
  localparam logic [17:0] ADDR_SFIFO_B = 18'h30914;
  localparam logic [17:0] ADDR_CLK_SEL = 18'h30a00;
  localparam logic [17:0] ADDR_FIFO_THR = 18'h30a01;

  // Reset values
  localparam logic [7:0] TX_CFG_RST = 8'h00;
  localparam logic [7:0] RX_CFG_RST = 8'h20;
  localparam logic [7:0] CLK_SEL_RST = 8'h00;
  localparam logic [7:0] FIFO_THR_RST = 8'h00;

  // Transmit configuration field positions
  localparam int TX_HALF_RATE_BIT = 0;
  localparam int TX_PWR_DOWN_BIT = 1;
  localparam int PREEMPH_LO_BIT = 2;
  localparam int PREEMPH_HI_BIT = 3;
  localparam int TX_HALF_SWING_BIT = 4;
  localparam int TX_RSVD_ZERO_BIT = 5;
  localparam int TX_RSVD_BIT = 6;
  localparam int TX_ENC_EN_BIT = 7;

  // Receive configuration field positions
  localparam int RX_HALF_RATE_BIT = 0;
  localparam int RX_PWR_DOWN_BIT = 1;
  localparam int RX_RSVD_BIT = 2;
  localparam int RX_DEC_EN_BIT = 3;
  localparam int FC_LINK_EN_BIT = 4;

  // Clock select field positions
  localparam int TX_SEL_A_LSB = 0;
  localparam int RX_SEL_A_LSB = 2;
  localparam int TX_SEL_B_LSB = 4;
  localparam int RX_SEL_B_LSB = 6;
  localparam int SEL_W = 2;

  // FIFO threshold field
  localparam int FIFO_MIN_LSB = 5;
  localparam int FIFO_MIN_W = 3;

  // Lane rate multipliers of the reference clock
  localparam logic [4:0] RATE_MULT_HALF = 5'h0a;
  localparam logic [4:0] RATE_MULT_FULL = 5'h14;

  // Returned clock divider: full period in serializer clock rises
  localparam int TX_CLK_DIV = 4;
  localparam logic [0:0] TX_DIV_HALF_LAST = 1'(TX_CLK_DIV / 2 - 1);

  typedef enum logic [1:0] {
    SLC_PE_NONE,
    SLC_PE_MID,
    SLC_PE_MAX
  } slc_preemph_t;

  typedef struct packed {
    logic half_rate;
    logic power_down;
    slc_preemph_t preemph;
    logic half_swing;
    logic encoder_en;
    logic [4:0] rate_mult;
  } slc_tx_ctl_t;

  typedef struct packed {
    logic half_rate;
    logic power_down;
    logic decoder_en;
    logic fc_link_en;
    logic [4:0] rate_mult;
  } slc_rx_ctl_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [17:0] addr;
    logic [7:0] wdata;
  } slc_reg_req_t;

endpackage

//--- rtl/slc_top.sv
`timescale 1ns/1ns
// Contract
// - Each quad returns a transmit clock at the fabric transmit clock frequency.
// - Returned transmit clock is the selected serializer character clock over four.
// - Each recovered lane clock is its own domain, synchronised separately.
// - Transmit half rate bit 0: set gives ten times, clear twenty times.
// - Transmit bit 1 powers down that channel's transmitter; resets clear.
// - Bits 2 and 3 pick preemphasis none, middle or maximum; reset clear.
// - Transmit bit 4 halves output swing; reset clear.
// - Transmit bit 7 enables the 8b/10b encoder; reset clear.
// - Receive half rate bit 0 sets receive lane rate and divider.
// - Receive bit 1 powers down that channel's receiver; reset clear.
// - Receive register resets to 0x20.
// - Receive bit 3 enables the 8b/10b decoder; reset clear.
// - Receive bit 4 enables link state machine, ignored in XAUI mode.
// - Quad status bits 0 to 3 show word alignment per channel.
// - Quad status bits 4 to 7 show multi-lane alignment per channel.
// - Second status bits 0 to 2 flag pair and quad FIFO overflow.
// - Bits 3 to 5 flag failed synchronisation; bits 6 and 7 zero.
// - Clock select bits 0-1 and 4-5 pick transmit clock source channel.
// - Bits 2-3 and 6-7 pick the quad receive clock source channel.
// - Threshold register bits 5 to 7 hold receive FIFO low threshold.
// - Near-end serial and far-end parallel loopback are supported.

module slc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_next;

  // Take a bit only once the second and third stages agree
  assign out_next = (s2_reg & s3_reg) | (sync_out & (s2_reg | s3_reg));

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      sync_out <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      sync_out <= out_next;
    end
  end
endmodule

module slc_top
  import slc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire slc_pkg::slc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // Serializer and recovered clocks, all quads
  input wire logic [slc_pkg::NUM_CH-1:0] serializer_char_clock,
  input wire logic [slc_pkg::NUM_CH-1:0] recovered_lane_clock,
  // Returned and receive clocks to fabric
  output logic [slc_pkg::NUM_QUADS-1:0] returned_tx_clock,
  output logic [slc_pkg::NUM_QUADS-1:0] quad_rx_clock,
  // Live status from the receive logic
  input wire logic [slc_pkg::NUM_CH-1:0] word_aligned_flag,
  input wire logic [slc_pkg::NUM_CH-1:0] multi_lane_aligned_flag,
  input wire logic [3:0] pair_fifo_overflow,
  input wire logic [1:0] quad_fifo_overflow,
  input wire logic [3:0] pair_sync_lost,
  input wire logic [1:0] quad_sync_lost,
  // Channel mode and loopback controls
  input wire logic [slc_pkg::NUM_CFG_CH-1:0] xaui_lane_mode,
  input wire logic [slc_pkg::NUM_CFG_CH-1:0] near_loop_en,
  input wire logic [slc_pkg::NUM_CFG_CH-1:0] far_loop_en,
  // Serial line
  input wire logic [slc_pkg::NUM_CFG_CH-1:0] serial_rx_in,
  input wire logic [slc_pkg::NUM_CFG_CH-1:0] ser_tx_bit,
  output logic [slc_pkg::NUM_CFG_CH-1:0] serial_tx_out,
  output logic [slc_pkg::NUM_CFG_CH-1:0] cdr_rx_bit,
  // Parallel data at the serializer boundary
  input wire logic [slc_pkg::NUM_CFG_CH-1:0][slc_pkg::PAR_W-1:0] fabric_tx_par,
  input wire logic [slc_pkg::NUM_CFG_CH-1:0][slc_pkg::PAR_W-1:0] des_rx_par,
  output logic [slc_pkg::NUM_CFG_CH-1:0][slc_pkg::PAR_W-1:0] ser_tx_par,
  // Channel controls to the transceiver
  output slc_pkg::slc_tx_ctl_t [slc_pkg::NUM_CFG_CH-1:0] tx_ctl,
  output slc_pkg::slc_rx_ctl_t [slc_pkg::NUM_CFG_CH-1:0] rx_ctl,
  output logic [slc_pkg::FIFO_MIN_W-1:0] rx_fifo_min_lsb
);
  import slc_pkg::*;

  localparam int STAT_W = 2 * NUM_CH + 12;
  localparam int PIN_W = 3 * NUM_CFG_CH;

  logic [NUM_CFG_CH-1:0][7:0] tx_cfg_reg;
  logic [NUM_CFG_CH-1:0][7:0] rx_cfg_reg;
  logic [7:0] clk_sel_reg;
  logic [7:0] fifo_thr_reg;
  logic [NUM_CFG_CH-1:0] tx_cfg_hit;
  logic [NUM_CFG_CH-1:0] rx_cfg_hit;
  logic [NUM_CFG_CH-1:0][17:0] tx_cfg_addr;
  logic [NUM_CFG_CH-1:0][17:0] rx_cfg_addr;
  logic [7:0] rd_mux;
  logic [7:0] align_a;
  logic [7:0] align_b;
  logic [7:0] sfifo_a;
  logic [7:0] sfifo_b;
  logic [STAT_W-1:0] stat_raw;
  logic [STAT_W-1:0] stat_sync;
  logic [PIN_W-1:0] pin_sync;
  logic [NUM_CFG_CH-1:0] xaui_s;
  logic [NUM_CFG_CH-1:0] near_s;
  logic [NUM_CFG_CH-1:0] rx_in_s;
  logic [NUM_CH-1:0] char_clk_s;
  logic [NUM_CH-1:0] rec_clk_s;
  logic [NUM_QUADS-1:0][SEL_W-1:0] tx_sel;
  logic [NUM_QUADS-1:0][SEL_W-1:0] rx_sel;
  logic [NUM_QUADS-1:0] char_sel;
  logic [NUM_QUADS-1:0] char_prev_reg;
  logic [NUM_QUADS-1:0] char_rise;
  logic [NUM_QUADS-1:0][0:0] div_cnt_reg;
  logic [NUM_QUADS-1:0][0:0] div_cnt_next;
  logic [NUM_QUADS-1:0] ret_clk_next;
  logic [NUM_QUADS-1:0] rx_clk_next;
  logic [NUM_CFG_CH-1:0] far_s;
  logic [7:0] thr_wdata;
  slc_tx_ctl_t [NUM_CFG_CH-1:0] tx_ctl_next;
  slc_rx_ctl_t [NUM_CFG_CH-1:0] rx_ctl_next;

  assign tx_cfg_addr = {ADDR_TX_CFG_BD, ADDR_TX_CFG_BC,
                        ADDR_TX_CFG_AD, ADDR_TX_CFG_AC};
  assign rx_cfg_addr = {ADDR_RX_CFG_BD, ADDR_RX_CFG_BC,
                        ADDR_RX_CFG_AD, ADDR_RX_CFG_AC};

  // Status inputs pass their own synchroniser before reaching the bus
  assign stat_raw = {quad_sync_lost, pair_sync_lost, quad_fifo_overflow,
                     pair_fifo_overflow, multi_lane_aligned_flag,
                     word_aligned_flag};

  slc_sync #(.W(STAT_W)) u_stat_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in(stat_raw),
    .sync_out(stat_sync)
  );

  // Mode and loopback pins
  slc_sync #(.W(PIN_W)) u_pin_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in({serial_rx_in, near_loop_en, xaui_lane_mode}),
    .sync_out(pin_sync)
  );

  slc_sync #(.W(NUM_CFG_CH)) u_far_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in(far_loop_en),
    .sync_out(far_s)
  );

  assign xaui_s = pin_sync[NUM_CFG_CH-1:0];
  assign near_s = pin_sync[2*NUM_CFG_CH-1:NUM_CFG_CH];
  assign rx_in_s = pin_sync[PIN_W-1:2*NUM_CFG_CH];

  // Each foreign clock gets its own synchroniser chain
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_clk_sync
      slc_sync #(.W(1)) u_char_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(serializer_char_clock[c]),
        .sync_out(char_clk_s[c])
      );
      slc_sync #(.W(1)) u_rec_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(recovered_lane_clock[c]),
        .sync_out(rec_clk_s[c])
      );
    end
  endgenerate

  // Status words, channels A to D from bit 0 upward
  localparam int MLA = NUM_CH;
  localparam int POV = 2 * NUM_CH;
  localparam int QOV = POV + 4;
  localparam int PSL = QOV + 2;
  localparam int QSL = PSL + 4;

  assign align_a = {stat_sync[MLA +: 4], stat_sync[0 +: 4]};
  assign align_b = {stat_sync[MLA+4 +: 4], stat_sync[4 +: 4]};
  assign sfifo_a = {2'h0, stat_sync[QSL], stat_sync[PSL +: 2],
                    stat_sync[QOV], stat_sync[POV +: 2]};
  assign sfifo_b = {2'h0, stat_sync[QSL+1], stat_sync[PSL+2 +: 2],
                    stat_sync[QOV+1], stat_sync[POV+2 +: 2]};

  // Address decode
  generate
    for (genvar i = 0; i < NUM_CFG_CH; i++) begin : g_hit
      assign tx_cfg_hit[i] = reg_req.addr == tx_cfg_addr[i];
      assign rx_cfg_hit[i] = reg_req.addr == rx_cfg_addr[i];
    end
  endgenerate

  // Read selection; unmapped addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NUM_CFG_CH; i++) begin
      if (tx_cfg_hit[i]) begin
        rd_mux = tx_cfg_reg[i] & ~(8'h01 << TX_RSVD_BIT);
      end
      if (rx_cfg_hit[i]) begin
        rd_mux = rx_cfg_reg[i];
      end
    end
    unique case (reg_req.addr)
      ADDR_ALIGN_A: rd_mux = align_a;
      ADDR_ALIGN_B: rd_mux = align_b;
      ADDR_SFIFO_A: rd_mux = sfifo_a;
      ADDR_SFIFO_B: rd_mux = sfifo_b;
      ADDR_CLK_SEL: rd_mux = clk_sel_reg;
      ADDR_FIFO_THR: rd_mux = fifo_thr_reg;
      default: rd_mux = rd_mux;
    endcase
  end

  // Only the threshold field of the threshold register is writable
  assign thr_wdata = reg_req.wdata & (8'(3'h7) << FIFO_MIN_LSB);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_req.rd_en & ~reg_req.wr_en;
      if (reg_req.rd_en && !reg_req.wr_en) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // Channel configuration registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CFG_CH; i++) begin
        tx_cfg_reg[i] <= TX_CFG_RST;
        rx_cfg_reg[i] <= RX_CFG_RST;
      end
    end else if (reg_req.wr_en) begin
      for (int i = 0; i < NUM_CFG_CH; i++) begin
        if (tx_cfg_hit[i]) begin
          tx_cfg_reg[i] <= reg_req.wdata;
        end
        if (rx_cfg_hit[i]) begin
          rx_cfg_reg[i] <= reg_req.wdata;
        end
      end
    end
  end

  // Common control registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clk_sel_reg <= CLK_SEL_RST;
      fifo_thr_reg <= FIFO_THR_RST;
    end else if (reg_req.wr_en) begin
      if (reg_req.addr == ADDR_CLK_SEL) begin
        clk_sel_reg <= reg_req.wdata;
      end
      if (reg_req.addr == ADDR_FIFO_THR) begin
        fifo_thr_reg <= thr_wdata;
      end
    end
  end

  assign rx_fifo_min_lsb = fifo_thr_reg[FIFO_MIN_LSB +: FIFO_MIN_W];

  // Channel controls, decoded from the register flops
  generate
    for (genvar i = 0; i < NUM_CFG_CH; i++) begin : g_ctl
      logic [1:0] pe_bits;
      assign pe_bits = {tx_cfg_reg[i][PREEMPH_HI_BIT],
                        tx_cfg_reg[i][PREEMPH_LO_BIT]};
      assign tx_ctl_next[i].half_rate = tx_cfg_reg[i][TX_HALF_RATE_BIT];
      assign tx_ctl_next[i].rate_mult = tx_cfg_reg[i][TX_HALF_RATE_BIT] ?
        RATE_MULT_HALF : RATE_MULT_FULL;
      assign tx_ctl_next[i].power_down =
        tx_cfg_reg[i][TX_PWR_DOWN_BIT];
      assign tx_ctl_next[i].preemph = (pe_bits == 2'h3) ? SLC_PE_MAX :
        (pe_bits == 2'h0) ? SLC_PE_NONE : SLC_PE_MID;
      assign tx_ctl_next[i].half_swing =
        tx_cfg_reg[i][TX_HALF_SWING_BIT];
      assign tx_ctl_next[i].encoder_en =
        tx_cfg_reg[i][TX_ENC_EN_BIT];
      assign rx_ctl_next[i].half_rate = rx_cfg_reg[i][RX_HALF_RATE_BIT];
      assign rx_ctl_next[i].rate_mult = rx_cfg_reg[i][RX_HALF_RATE_BIT] ?
        RATE_MULT_HALF : RATE_MULT_FULL;
      assign rx_ctl_next[i].power_down =
        rx_cfg_reg[i][RX_PWR_DOWN_BIT];
      assign rx_ctl_next[i].decoder_en =
        rx_cfg_reg[i][RX_DEC_EN_BIT];
      // Link machine enable is forced off by XAUI mode
      assign rx_ctl_next[i].fc_link_en =
        rx_cfg_reg[i][FC_LINK_EN_BIT] & ~xaui_s[i];
    end
  endgenerate

  // Controls leave the block from flops
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CFG_CH; i++) begin
        tx_ctl[i] <= '{1'b0, 1'b0, SLC_PE_NONE, 1'b0, 1'b0, RATE_MULT_FULL};
        rx_ctl[i] <= '{1'b0, 1'b0, 1'b0, 1'b0, RATE_MULT_FULL};
      end
    end else begin
      tx_ctl <= tx_ctl_next;
      rx_ctl <= rx_ctl_next;
    end
  end

  // Clock source selectors; code {bit1,bit0} is the channel index
  assign tx_sel[0] = clk_sel_reg[TX_SEL_A_LSB +: SEL_W];
  assign tx_sel[1] = clk_sel_reg[TX_SEL_B_LSB +: SEL_W];
  assign rx_sel[0] = clk_sel_reg[RX_SEL_A_LSB +: SEL_W];
  assign rx_sel[1] = clk_sel_reg[RX_SEL_B_LSB +: SEL_W];

  // Returned transmit clock toggles every second rise of the source
  generate
    for (genvar q = 0; q < NUM_QUADS; q++) begin : g_quad_clk
      assign char_sel[q] = char_clk_s[q*CH_PER_QUAD + int'(tx_sel[q])];
      assign char_rise[q] = char_sel[q] & ~char_prev_reg[q];
      assign div_cnt_next[q] = (div_cnt_reg[q] == TX_DIV_HALF_LAST) ?
                               1'b0 : div_cnt_reg[q] + 1'b1;
      assign ret_clk_next[q] = (div_cnt_reg[q] == TX_DIV_HALF_LAST) ?
                               ~returned_tx_clock[q] :
                               returned_tx_clock[q];
      assign rx_clk_next[q] =
        rec_clk_s[q*CH_PER_QUAD + int'(rx_sel[q])];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      char_prev_reg <= '0;
      div_cnt_reg <= '0;
      returned_tx_clock <= '0;
      quad_rx_clock <= '0;
    end else begin
      char_prev_reg <= char_sel;
      quad_rx_clock <= rx_clk_next;
      for (int q = 0; q < NUM_QUADS; q++) begin
        if (char_rise[q]) begin
          div_cnt_reg[q] <= div_cnt_next[q];
          returned_tx_clock[q] <= ret_clk_next[q];
        end
      end
    end
  end

  // Near-end serial and far-end parallel loopback paths
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      serial_tx_out <= '0;
      cdr_rx_bit <= '0;
      ser_tx_par <= '0;
    end else begin
      serial_tx_out <= ser_tx_bit;
      for (int i = 0; i < NUM_CFG_CH; i++) begin
        cdr_rx_bit[i] <= near_s[i] ? serial_tx_out[i] : rx_in_s[i];
        ser_tx_par[i] <= far_s[i] ? des_rx_par[i] : fabric_tx_par[i];
      end
    end
  end

endmodule

//--- test/slc_lane_model.sv
`timescale 1ns/1ns
module slc_lane_model (
  // Run control
  input wire logic run,
  // Clocks toward the block
  output logic [7:0] char_clk,
  output logic [7:0] rec_clk
);
  initial begin
    char_clk = 8'h00;
    rec_clk = 8'h00;
  end
  // Each lane has its own period so the chosen source shows in the period
  for (genvar k = 0; k < 8; k++) begin : g_lane
    // Even half periods keep every toggle off the rising edge
    always begin
      #(100 + 20 * k);
      if (run) char_clk[k] = ~char_clk[k];
    end
    always begin
      #(106 + 20 * k);
      if (run) rec_clk[k] = ~rec_clk[k];
    end
  end
endmodule

//--- test/slc_top_monitor.sv
`timescale 1ns/1ns
module slc_top_monitor
  import slc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire slc_pkg::slc_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  // Clocks
  input wire logic [7:0] serializer_char_clock,
  input wire logic [7:0] recovered_lane_clock,
  input wire logic [1:0] returned_tx_clock,
  input wire logic [1:0] quad_rx_clock,
  // Lane pins and data
  input wire logic [3:0] xaui_lane_mode,
  input wire logic [3:0] near_loop_en,
  input wire logic [3:0] far_loop_en,
  input wire logic [3:0] ser_tx_bit,
  input wire logic [3:0] serial_tx_out,
  input wire logic [3:0] cdr_rx_bit,
  input wire logic [3:0][9:0] fabric_tx_par,
  input wire logic [3:0][9:0] des_rx_par,
  input wire logic [3:0][9:0] ser_tx_par,
  input wire slc_pkg::slc_tx_ctl_t [3:0] tx_ctl,
  input wire slc_pkg::slc_rx_ctl_t [3:0] rx_ctl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_rd;
    reg_req.rd_en && !reg_req.wr_en;
  endsequence
  sequence s_char_still;
    ($stable(serializer_char_clock) && !reg_req.wr_en)[*8];
  endsequence
  sequence s_rec_still;
    ($stable(recovered_lane_clock) && !reg_req.wr_en)[*8];
  endsequence
  rd_pulse_a: assert property (s_rd |=> reg_rd_valid)
    else $error("read not answered");
  rd_quiet_a: assert property (!reg_req.rd_en |=> !reg_rd_valid)
    else $error("read valid without read");
  rdata_hold_a: assert property (
    $past(rstn) && !reg_rd_valid |-> $stable(reg_rdata))
    else $error("read data moved without read");
  txclk_still_a: assert property (
    s_char_still |=> $stable(returned_tx_clock))
    else $error("returned clock moved without source");
  rxclk_still_a: assert property (
    s_rec_still |=> $stable(quad_rx_clock))
    else $error("receive clock moved without source");
  tx_out_a: assert property (
    $past(rstn) |-> serial_tx_out == $past(ser_tx_bit))
    else $error("serial output not one cycle behind");
  for (genvar i = 0; i < 4; i++) begin : g_ch
    tx_rate_a: assert property (
      tx_ctl[i].rate_mult ==
      (tx_ctl[i].half_rate ? RATE_MULT_HALF : RATE_MULT_FULL))
      else $error("transmit rate wrong");
    rx_rate_a: assert property (
      rx_ctl[i].rate_mult ==
      (rx_ctl[i].half_rate ? RATE_MULT_HALF : RATE_MULT_FULL))
      else $error("receive rate wrong");
    fc_gate_a: assert property (
      xaui_lane_mode[i] [*8] |-> !rx_ctl[i].fc_link_en)
      else $error("link machine on in xaui mode");
    far_loop_a: assert property (
      far_loop_en[i] [*8] |-> ser_tx_par[i] == $past(des_rx_par[i]))
      else $error("far loop data wrong");
    near_loop_a: assert property (
      near_loop_en[i] [*8] |-> cdr_rx_bit[i] == $past(serial_tx_out[i]))
      else $error("near loop data wrong");
  end
endmodule
bind slc_top slc_top_monitor u_slc_top_monitor (.*);

//--- test/tb.sv
`timescale 1ns/1ns
module tb;
  import slc_pkg::*;
  localparam logic [17:0] TXA [4] = '{ADDR_TX_CFG_AC, ADDR_TX_CFG_AD,
    ADDR_TX_CFG_BC, ADDR_TX_CFG_BD};
  localparam logic [17:0] STA [6] = '{ADDR_ALIGN_A, ADDR_SFIFO_A,
    ADDR_ALIGN_B, ADDR_SFIFO_B, ADDR_CLK_SEL, ADDR_FIFO_THR};
  logic ref_clk, rstn, run, reg_rd_valid;
  slc_reg_req_t reg_req;
  logic [7:0] reg_rdata, serializer_char_clock, recovered_lane_clock;
  logic [7:0] word_aligned_flag, multi_lane_aligned_flag;
  logic [1:0] returned_tx_clock, quad_rx_clock;
  logic [1:0] quad_fifo_overflow, quad_sync_lost;
  logic [3:0] pair_fifo_overflow, pair_sync_lost, xaui_lane_mode;
  logic [3:0] near_loop_en, far_loop_en, serial_rx_in, ser_tx_bit;
  logic [3:0] serial_tx_out, cdr_rx_bit;
  logic [3:0][9:0] fabric_tx_par, des_rx_par, ser_tx_par;
  slc_tx_ctl_t [3:0] tx_ctl;
  slc_rx_ctl_t [3:0] rx_ctl;
  logic [2:0] rx_fifo_min_lsb;
  int err_total, cmp_count;

  slc_top u_slc_top (.*);
  slc_lane_model u_slc_lane_model (.run(run),
    .char_clk(serializer_char_clock), .rec_clk(recovered_lane_clock));

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task chk_per(input string n, input int e, input int g);
    cmp_count++;
    if (g < e - 2 || g > e + 2) begin
      err_total++;
      $display("Error %s exp %0d got %0d", n, e, g);
    end
  endtask
  task wr(input logic [17:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    reg_req = '0;
  endtask
  task rd(input logic [17:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk);
    reg_req = '0;
    chk("rd_valid", 16'h1, {15'h0, reg_rd_valid});
    chk("rdata", {8'h0, e}, {8'h0, reg_rdata});
  endtask
  task per(input int q, input int rx, input int e);
    int n, t, r;
    logic p, c;
    n = 0;
    t = 0;
    r = 0;
    p = 1'b1;
    repeat (1000) begin
      @(negedge ref_clk);
      c = rx ? quad_rx_clock[q] : returned_tx_clock[q];
      n++;
      if (c === 1'b1 && p === 1'b0) begin
        r++;
        if (r == 3) break;
        t = n;
      end
      p = c;
    end
    chk_per("clock_period", e, n - t);
  endtask

  task t_reset;
    for (int c = 0; c < 4; c++) begin
      rd(TXA[c], TX_CFG_RST);
      rd(TXA[c] + 18'h1, RX_CFG_RST);
    end
    for (int i = 0; i < 6; i++) begin
      rd(STA[i], 8'h00);
    end
    rd(18'h30024, 8'h00);
  endtask
  task t_cfg;
    logic [1:0] p;
    logic [7:0] d;
    slc_preemph_t pe;
    slc_tx_ctl_t et;
    slc_rx_ctl_t er;
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 4; i++) begin
        p = 2'(i);
        pe = p == 2'd3 ? SLC_PE_MAX : (p == 2'd0 ? SLC_PE_NONE : SLC_PE_MID);
        d = {p[1], 2'b00, p[0], p, p[1], p[0]};
        wr(TXA[c], d);
        rd(TXA[c], d);
        et = '{p[0], p[1], pe, p[0], p[1],
          p[0] ? RATE_MULT_HALF : RATE_MULT_FULL};
        chk("tx_ctl", 16'(et), 16'(tx_ctl[c]));
        d = {3'b001, p[0], p[1], 1'b0, p[1], p[0]};
        wr(TXA[c] + 18'h1, d);
        rd(TXA[c] + 18'h1, d);
        er = '{p[0], p[1], p[1], p[0],
          p[0] ? RATE_MULT_HALF : RATE_MULT_FULL};
        chk("rx_ctl", 16'(er), 16'(rx_ctl[c]));
      end
    end
  endtask
  task t_ro;
    wr(TXA[0], 8'h40);
    rd(TXA[0], 8'h00);
    wr(ADDR_ALIGN_A, 8'hff);
    rd(ADDR_ALIGN_A, 8'h00);
    wr(18'h30024, 8'hff);
    rd(18'h30024, 8'h00);
    wr(TXA[0] + 18'h1, 8'h30);
    xaui_lane_mode = 4'h1;
    repeat (8) @(negedge ref_clk);
    chk("fc_link_en", 16'h0, {15'h0, rx_ctl[0].fc_link_en});
    xaui_lane_mode = 4'h0;
    repeat (8) @(negedge ref_clk);
    chk("fc_link_en", 16'h1, {15'h0, rx_ctl[0].fc_link_en});
    wr(ADDR_FIFO_THR, 8'hff);
    rd(ADDR_FIFO_THR, 8'he0);
    chk("fifo_min", 16'h7, 16'(rx_fifo_min_lsb));
    wr(ADDR_FIFO_THR, 8'h40);
    chk("fifo_min", 16'h2, 16'(rx_fifo_min_lsb));
  endtask
  task t_status;
    for (int i = 0; i < 2; i++) begin
      @(negedge ref_clk);
      word_aligned_flag = i ? 8'h5a : 8'hc3;
      multi_lane_aligned_flag = i ? 8'h96 : 8'h3c;
      {pair_fifo_overflow, quad_fifo_overflow} = i ? 6'h25 : 6'h1a;
      {pair_sync_lost, quad_sync_lost} = i ? 6'h19 : 6'h26;
      repeat (6) @(negedge ref_clk);
      rd(ADDR_ALIGN_A, {multi_lane_aligned_flag[3:0],
        word_aligned_flag[3:0]});
      rd(ADDR_ALIGN_B, {multi_lane_aligned_flag[7:4],
        word_aligned_flag[7:4]});
      rd(ADDR_SFIFO_A, {2'b00, quad_sync_lost[0], pair_sync_lost[1:0],
        quad_fifo_overflow[0],
        pair_fifo_overflow[1:0]});
      rd(ADDR_SFIFO_B, {2'b00, quad_sync_lost[1], pair_sync_lost[3:2],
        quad_fifo_overflow[1],
        pair_fifo_overflow[3:2]});
    end
  endtask
  task t_loop;
    @(negedge ref_clk);
    far_loop_en = 4'h5;
    near_loop_en = 4'ha;
    serial_rx_in = 4'h3;
    ser_tx_bit = 4'hc;
    fabric_tx_par = {10'h3a5, 10'h15a, 10'h2c3, 10'h0f0};
    des_rx_par = {10'h0c6, 10'h339, 10'h1e1, 10'h20f};
    repeat (8) @(negedge ref_clk);
    for (int c = 0; c < 4; c++) begin
      chk("ser_tx_par", 16'(c % 2 ? fabric_tx_par[c] : des_rx_par[c]),
        16'(ser_tx_par[c]));
    end
    chk("serial_tx_out", 16'hc, 16'(serial_tx_out));
    chk("cdr_rx_bit", 16'h9, 16'(cdr_rx_bit));
    far_loop_en = 4'h0;
    near_loop_en = 4'h0;
  endtask
  task t_clk;
    run = 1'b1;
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_CLK_SEL, {4{2'(v)}});
      rd(ADDR_CLK_SEL, {4{2'(v)}});
      for (int q = 0; q < 2; q++) begin
        per(q, 0, 80 + 16 * (4 * q + v));
        per(q, 1, 21 + 4 * (4 * q + v));
      end
    end
    run = 1'b0;
  endtask
  task tally_and_finish;
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    err_total = 0;
    cmp_count = 0;
    run = 1'b0;
    rstn = 1'b0;
    reg_req = '0;
    {word_aligned_flag, multi_lane_aligned_flag} = '0;
    {pair_fifo_overflow, quad_fifo_overflow} = '0;
    {pair_sync_lost, quad_sync_lost} = '0;
    {xaui_lane_mode, near_loop_en, far_loop_en} = '0;
    {serial_rx_in, ser_tx_bit} = '0;
    fabric_tx_par = '0;
    des_rx_par = '0;
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    t_reset;
    t_cfg;
    t_ro;
    t_status;
    t_loop;
    t_clk;
    tally_and_finish;
  end
endmodule
